// ---- vcu_pkg.sv ----
// vcu_pkg: shared constants, state type and number-format helpers for the value calculate unit.
// assumes a single 40 MHz clock domain and APB register access with 32-bit data.
package vcu_pkg;

  // apb map; data memory words sit in a window of one aligned word each
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFF_SRC = 12'h004;
  localparam logic [APB_AW-1:0] OFF_RES = 12'h008;
  localparam logic [APB_AW-1:0] OFF_STAT = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_MASK = 12'h010;
  localparam logic [APB_AW-1:0] OFF_DM_BASE = 12'h400;
  localparam int DM_DEPTH_DEF = 256;
  localparam int DM_DEPTH_MAX = 256;

  // control register fields
  localparam int CTRL_ADDR_BIT = 16;
  localparam int CTRL_IND_BIT = 17;
  localparam int CTRL_EXEC_BIT = 31;

  // status / mask layout
  localparam int EVT_W = 2;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_ERR_BIT = 1;

  // operand codes and limits
  localparam logic [15:0] OP_SINE = 16'h0000;
  localparam logic [15:0] OP_COSINE = 16'h0001;
  localparam logic [15:0] ANGLE_MAX_BCD = 16'h0900;
  localparam logic [15:0] ANGLE_ZERO_BCD = 16'h0000;
  localparam logic [15:0] SAT_BCD = 16'h9999;
  localparam logic [15:0] BCD_MAX_BIN = 16'h270F;

  // table header fields and word offsets
  localparam int SEG_LSB = 0;
  localparam int SEG_MSB = 7;
  localparam int OUT_BIN_BIT = 14;
  localparam int IN_BIN_BIT = 15;
  localparam logic [17:0] TBL_MAX_OFS = 18'h00001;
  localparam logic [17:0] TBL_Y0_OFS = 18'h00002;
  localparam logic [17:0] TBL_TAIL = 18'h00002;

  // cordic scaling: q2.22 fixed point
  localparam int CORDIC_W = 26;
  localparam int CORDIC_ITER = 22;
  localparam int ANGLE_W = 10;
  // pi/1800 in q2.22, times 2^8: one tenth of a degree in radians
  localparam logic [20:0] DEG_TO_RAD_Q8 = 21'h1C9870;
  localparam logic signed [CORDIC_W-1:0] CORDIC_GAIN = 26'sh026DD3B;
  localparam logic signed [CORDIC_W-1:0] CORDIC_ONE = 26'sh0400000;
  localparam logic [22:0] TRIG_BIAS = 23'h000008;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PTR = 3'h1,
    ST_HEAD = 3'h3,
    ST_SEG = 3'h2,
    ST_DIV = 3'h6,
    ST_DONE = 3'h7,
    ST_TRIG = 3'h5
  } vcu_state_t;

  function automatic logic bcd_ok(input logic [15:0] b);
    return (b[15:12] < 4'hA) && (b[11:8] < 4'hA) && (b[7:4] < 4'hA) && (b[3:0] < 4'hA);
  endfunction : bcd_ok

  function automatic logic [15:0] bcd2bin(input logic [15:0] b);
    return 16'(16'(b[15:12]) * 16'h03E8 + 16'(b[11:8]) * 16'h0064
               + 16'(b[7:4]) * 16'h000A + 16'(b[3:0]));
  endfunction : bcd2bin

  function automatic logic [15:0] to_bin(input logic [15:0] w, input logic is_bin);
    return is_bin ? w : bcd2bin(w);
  endfunction : to_bin

  // double dabble; values above 9999 are caught before this is used
  function automatic logic [15:0] bin2bcd(input logic [15:0] v);
    logic [31:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (s[16+4*d +: 4] > 4'h4) s[16+4*d +: 4] = s[16+4*d +: 4] + 4'h3;
      end
      s = s << 1;
    end
    return s[31:16];
  endfunction : bin2bcd

  // four truncated fraction digits; a tiny bias hides cordic error below 1e-4
  function automatic logic [15:0] frac2bcd(input logic signed [CORDIC_W-1:0] q);
    logic [22:0] f;
    logic [25:0] p;
    logic [15:0] d;
    d = 16'h0000;
    if (q < 0) return 16'h0000;
    if (q >= CORDIC_ONE) return SAT_BCD;
    f = {1'b0, q[21:0]} + TRIG_BIAS;
    if (f[22]) return SAT_BCD;
    for (int i = 0; i < 4; i++) begin
      p = 26'({4'h0, f[21:0]} * 26'h000000A);
      d = {d[11:0], p[25:22]};
      f = {1'b0, p[21:0]};
    end
    return d;
  endfunction : frac2bcd

endpackage : vcu_pkg

// ---- vcu_cordic_if.sv ----
// vcu_cordic_if: start/angle request and sine/cosine answer between calculator and cordic.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface vcu_cordic_if;
  import vcu_pkg::*;
  logic start;
  logic [ANGLE_W-1:0] angle;
  logic done;
  logic signed [CORDIC_W-1:0] sin_q;
  logic signed [CORDIC_W-1:0] cos_q;
  modport core(input start, input angle, output done, output sin_q, output cos_q);
  modport user(output start, output angle, input done, input sin_q, input cos_q);
endinterface : vcu_cordic_if

// ---- vcu_cordic.sv ----
// vcu_cordic: iterative rotation-mode cordic, angle in binary tenths of a degree (0..900).
// assumes start is a one-cycle pulse and is not raised again before done.
`timescale 1ns/1ps
module vcu_cordic #(
  parameter int ITER = vcu_pkg::CORDIC_ITER
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  vcu_cordic_if.core cif
);
  import vcu_pkg::*;

  logic signed [CORDIC_W-1:0] x;
  logic signed [CORDIC_W-1:0] y;
  logic signed [CORDIC_W-1:0] z;
  logic [4:0] step;
  logic run;
  logic done;

  generate
    if (ITER < 8 || ITER > 22) begin : g_bad_iter
      $error("vcu_cordic: ITER must lie in 8..22");
    end
  endgenerate

  // arctangent of 2^-i in q2.22; beyond i=7 it equals 2^-i to within one lsb
  function automatic logic signed [CORDIC_W-1:0] atan_step(input logic [4:0] i);
    case (i)
      5'h00: atan_step = 26'sh03243F7;
      5'h01: atan_step = 26'sh01DAC67;
      5'h02: atan_step = 26'sh00FADBA;
      5'h03: atan_step = 26'sh007F56E;
      5'h04: atan_step = 26'sh003FEAB;
      5'h05: atan_step = 26'sh001FFD5;
      5'h06: atan_step = 26'sh000FFFA;
      5'h07: atan_step = 26'sh0007FFF;
      default: atan_step = CORDIC_ONE >>> i;
    endcase
  endfunction : atan_step

  // degree tenths to radians, scaled by 2^8 more to keep the conversion error tiny
  wire [31:0] z_scaled = 32'(cif.angle) * 32'(DEG_TO_RAD_Q8);
  wire signed [CORDIC_W-1:0] z_start = CORDIC_W'(z_scaled >> 8);
  wire signed [CORDIC_W-1:0] x_sh = x >>> step;
  wire signed [CORDIC_W-1:0] y_sh = y >>> step;
  wire z_neg = z[CORDIC_W-1];

  // one micro-rotation per clock; results hold until the next start
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      x <= '0;
      y <= '0;
      z <= '0;
      step <= 5'h00;
      run <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cif.start) begin
        x <= CORDIC_GAIN;
        y <= '0;
        z <= z_start;
        step <= 5'h00;
        run <= 1'b1;
      end else if (run) begin
        x <= z_neg ? x + y_sh : x - y_sh;
        y <= z_neg ? y - x_sh : y + x_sh;
        z <= z_neg ? z + atan_step(step) : z - atan_step(step);
        step <= step + 5'h01;
        if (step == 5'(ITER - 1)) begin
          run <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign cif.done = done;
  assign cif.sin_q = y;
  assign cif.cos_q = x;

endmodule : vcu_cordic

// ---- vcu_value_calc.sv ----
// vcu_value_calc: value calculate unit with apb registers and its own data memory window.
// assumes an apb master on ref_clk_i; the table lives in the memory window.
//
// Summary of operation
// RULE1 - nothing is computed and the result stays put unless execution is requested
// RULE2 - operand 0000 immediate computes the sine of the source angle
// RULE3 - operand 0001 immediate computes the cosine of the source angle
// RULE4 - software supplies the angle as bcd tenths of a degree, at most 90.0
// RULE5 - a trig angle above 0900 raises the error flag, no result written
// RULE6 - trig result is four bcd fraction digits, lower digits truncated
// RULE7 - a true result of one is written as 0.9999
// RULE8 - equal flag is set when the written result is zero, else cleared
// RULE9 - a non-bcd or out-of-range indirect pointer raises the error flag
// RULE10 - a table that cannot be read raises the error flag
// RULE11 - an address operand selects linear approximation from that table word
// RULE12 - header bits 7..0 give segment count minus one in binary
// RULE13 - header bit 14 selects output form, bit 15 input form; one is binary
// RULE14 - software keeps the table contiguous from header to header plus 2m+2
// RULE15 - the result follows straight segments through the stored breakpoints
// RULE16 - after the header come the maximum input, then breakpoints x then y
// RULE17 - inputs between breakpoints interpolate linearly; a breakpoint x gives its y
`timescale 1ns/1ps
module vcu_value_calc #(
  parameter int DM_DEPTH = vcu_pkg::DM_DEPTH_DEF
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [vcu_pkg::APB_AW-1:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic irq_o
);
  import vcu_pkg::*;

  localparam int AW = $clog2(DM_DEPTH);

  generate
    if (DM_DEPTH < 16 || DM_DEPTH > DM_DEPTH_MAX) begin : g_bad_depth
      $error("vcu_value_calc: DM_DEPTH must lie in 16..256");
    end
  endgenerate

  logic [15:0] dm [DM_DEPTH];
  logic [15:0] ctrl_op;
  logic ctrl_addr;
  logic ctrl_ind;
  logic [15:0] src;
  logic [15:0] res;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] mask;
  logic er_flag;
  logic eq_flag;
  vcu_state_t state;
  logic err;
  logic val_final;
  logic in_bin;
  logic out_bin;
  logic [15:0] base;
  logic [15:0] xin;
  logic [15:0] xprev;
  logic [15:0] yprev;
  logic [15:0] val;
  logic [8:0] seg_last;
  logic [8:0] k;
  logic [31:0] num;
  logic [16:0] rem;
  logic [15:0] den;
  logic [4:0] dcnt;
  logic neg;

  vcu_cordic_if cif();

  vcu_cordic #(
    .ITER(CORDIC_ITER)
  ) u_cordic (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .cif(cif)
  );

  // apb decode; unaligned or unmapped addresses answer with pslverr
  wire bus_setup = psel_i & ~penable_i;
  wire bus_wr = psel_i & penable_i & pwrite_i;
  wire [APB_AW-1:0] dm_ofs = paddr_i - OFF_DM_BASE;
  wire dm_hit = (paddr_i >= OFF_DM_BASE) && (paddr_i[1:0] == 2'h0)
                && (32'(dm_ofs[APB_AW-1:2]) < DM_DEPTH);
  wire [AW-1:0] dm_bus_idx = dm_ofs[AW+1:2];
  wire hit_ctrl = paddr_i == OFF_CTRL;
  wire hit_src = paddr_i == OFF_SRC;
  wire hit_res = paddr_i == OFF_RES;
  wire hit_stat = paddr_i == OFF_STAT;
  wire hit_mask = paddr_i == OFF_MASK;
  wire reg_hit = hit_ctrl | hit_src | hit_res | hit_stat | hit_mask | dm_hit;
  wire busy = state != ST_IDLE;

  // read words; status shows sticky events low, live state in bits 8..10
  wire [31:0] ctrl_word = {14'h0000, ctrl_ind, ctrl_addr, ctrl_op};
  wire [31:0] stat_word = {21'h000000, eq_flag, er_flag, busy, 6'h00, evt};
  wire [31:0] rd_word = hit_ctrl ? ctrl_word :
                        hit_src ? {16'h0000, src} :
                        hit_res ? {16'h0000, res} :
                        hit_stat ? stat_word :
                        hit_mask ? {30'h00000000, mask} :
                        dm_hit ? {16'h0000, dm[dm_bus_idx]} : 32'h00000000;

  // read data is captured in the setup cycle so the access phase needs no wait
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (bus_setup) begin
      prdata_o <= rd_word;
      pslverr_o <= ~reg_hit;
    end
  end

  assign pready_o = 1'b1;

  // the execution condition is a ctrl write with the exec bit while idle
  wire wr_ctrl = bus_wr & hit_ctrl;
  wire go = wr_ctrl & pwdata_i[CTRL_EXEC_BIT] & ~busy;  // RULE1
  wire go_addr = pwdata_i[CTRL_ADDR_BIT];
  wire go_ind = pwdata_i[CTRL_IND_BIT];
  wire [15:0] go_op = pwdata_i[15:0];

  // ctrl and source are frozen while busy so a running evaluation sees stable operands
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_op <= 16'h0000;
      ctrl_addr <= 1'b0;
      ctrl_ind <= 1'b0;
      src <= 16'h0000;
      mask <= '0;
    end else begin
      if (wr_ctrl && !busy) begin
        ctrl_op <= go_op;
        ctrl_addr <= go_addr;
        ctrl_ind <= go_ind;
      end
      if (bus_wr && hit_src && !busy) src <= pwdata_i[15:0];
      if (bus_wr && hit_mask) mask <= pwdata_i[EVT_W-1:0];
    end
  end

  // data memory; software may rewrite it mid-run, at its own risk
  always_ff @(posedge ref_clk_i) begin
    if (bus_wr && dm_hit) dm[dm_bus_idx] <= pwdata_i[15:0];
  end

  // trig checks
  wire [15:0] angle_bin = bcd2bin(src);
  wire trig_bad = !bcd_ok(src) || (src > ANGLE_MAX_BCD);  // RULE5
  wire imm_bad = go_op > OP_COSINE;
  assign cif.start = go & ~go_addr & ~trig_bad & ~imm_bad;  // RULE2 RULE3
  assign cif.angle = angle_bin[ANGLE_W-1:0];
  wire signed [CORDIC_W-1:0] trig_q = (ctrl_op == OP_COSINE) ? cif.cos_q : cif.sin_q;
  wire trig_one = ((ctrl_op == OP_SINE) && (src == ANGLE_MAX_BCD))
                  || ((ctrl_op == OP_COSINE) && (src == ANGLE_ZERO_BCD));
  wire [15:0] trig_word = trig_one ? SAT_BCD : frac2bcd(trig_q);  // RULE6 RULE7

  // indirect pointer: the addressed word must hold a bcd address inside memory
  wire [15:0] ptr_word = dm[ctrl_op[AW-1:0]];
  wire [15:0] ptr_bin = bcd2bin(ptr_word);
  wire ptr_bad = (32'(ctrl_op) >= DM_DEPTH) || !bcd_ok(ptr_word)
                 || (32'(ptr_bin) >= DM_DEPTH);  // RULE9

  // header decode and table extent check
  wire [15:0] hdr = dm[base[AW-1:0]];
  wire [8:0] seg_m = 9'(hdr[SEG_MSB:SEG_LSB]) + 9'h001;  // RULE12
  wire h_in_bin = hdr[IN_BIN_BIT];  // RULE13
  wire h_out_bin = hdr[OUT_BIN_BIT];  // RULE13
  wire [17:0] tbl_end = 18'(base) + 18'({seg_m, 1'b0}) + TBL_TAIL;
  wire head_oob = 32'(tbl_end) >= DM_DEPTH;  // RULE10
  wire src_bad = !h_in_bin && !bcd_ok(src);
  wire [17:0] xmax_idx = 18'(base) + TBL_MAX_OFS;
  wire [17:0] y0_idx = 18'(base) + TBL_Y0_OFS;
  wire [15:0] xmax_v = to_bin(dm[xmax_idx[AW-1:0]], h_in_bin);  // RULE16
  wire [15:0] y0_v = to_bin(dm[y0_idx[AW-1:0]], h_out_bin);
  wire [15:0] src_v = to_bin(src, h_in_bin);

  // breakpoint k: x at base+2k+1, y right after it
  wire [17:0] xk_idx = 18'(base) + 18'({k, 1'b0}) + TBL_MAX_OFS;
  wire [17:0] yk_idx = xk_idx + TBL_MAX_OFS;
  wire [15:0] xk_v = to_bin(dm[xk_idx[AW-1:0]], in_bin);  // RULE16
  wire [15:0] yk_v = to_bin(dm[yk_idx[AW-1:0]], out_bin);
  wire seg_hit = xin <= xk_v;
  wire seg_exact = xin == xk_v;
  wire seg_down = yk_v < yprev;
  wire [15:0] dy = seg_down ? yprev - yk_v : yk_v - yprev;
  wire [15:0] dx = xin - xprev;

  // restoring divider step
  wire [16:0] rem_sh = {rem[15:0], num[31]};
  wire rem_ge = rem_sh >= {1'b0, den};
  wire [31:0] quo_next = {num[30:0], rem_ge};

  // final word and its own error case
  wire range_bad = !val_final && !out_bin && (val > BCD_MAX_BIN);
  wire done_err = err | range_bad;
  wire [15:0] out_word = (val_final | out_bin) ? val : bin2bcd(val);

  // evaluation sequencer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
      err <= 1'b0;
      val_final <= 1'b0;
      in_bin <= 1'b0;
      out_bin <= 1'b0;
      base <= 16'h0000;
      xin <= 16'h0000;
      xprev <= 16'h0000;
      yprev <= 16'h0000;
      val <= 16'h0000;
      seg_last <= 9'h000;
      k <= 9'h000;
      num <= 32'h00000000;
      rem <= 17'h00000;
      den <= 16'h0000;
      dcnt <= 5'h00;
      neg <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            err <= 1'b0;
            val_final <= 1'b0;
            if (!go_addr) begin
              if (trig_bad || imm_bad) begin
                err <= 1'b1;  // RULE5
                state <= ST_DONE;
              end else begin
                state <= ST_TRIG;
              end
            end else if (go_ind) begin
              state <= ST_PTR;
            end else begin
              base <= go_op;  // RULE11
              state <= ST_HEAD;
            end
          end
        end
        ST_PTR: begin
          if (ptr_bad) begin
            err <= 1'b1;  // RULE9
            state <= ST_DONE;
          end else begin
            base <= ptr_bin;
            state <= ST_HEAD;
          end
        end
        ST_HEAD: begin
          in_bin <= h_in_bin;
          out_bin <= h_out_bin;
          seg_last <= seg_m;
          if (head_oob || src_bad) begin
            err <= 1'b1;  // RULE10
            state <= ST_DONE;
          end else begin
            xin <= (src_v > xmax_v) ? xmax_v : src_v;
            xprev <= 16'h0000;
            yprev <= y0_v;
            k <= 9'h001;
            state <= ST_SEG;
          end
        end
        ST_SEG: begin
          if (seg_hit && seg_exact) begin
            val <= yk_v;  // RULE17
            state <= ST_DONE;
          end else if (seg_hit) begin
            num <= 32'(dy) * 32'(dx);  // RULE15
            den <= xk_v - xprev;
            neg <= seg_down;
            rem <= 17'h00000;
            dcnt <= 5'h00;
            state <= ST_DIV;
          end else if (k == seg_last) begin
            val <= yk_v;
            state <= ST_DONE;
          end else begin
            k <= k + 9'h001;
            xprev <= xk_v;
            yprev <= yk_v;
          end
        end
        ST_DIV: begin
          rem <= rem_ge ? rem_sh - {1'b0, den} : rem_sh;
          num <= quo_next;
          dcnt <= dcnt + 5'h01;
          if (dcnt == 5'h1F) begin
            val <= neg ? yprev - quo_next[15:0] : yprev + quo_next[15:0];  // RULE17
            state <= ST_DONE;
          end
        end
        ST_TRIG: begin
          if (cif.done) begin
            val <= trig_word;  // RULE6
            val_final <= 1'b1;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // destination and flags change only when an evaluation completes
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res <= 16'h0000;
      er_flag <= 1'b0;
      eq_flag <= 1'b0;
    end else if (state == ST_DONE) begin
      if (done_err) begin
        er_flag <= 1'b1;  // RULE9 RULE10
        eq_flag <= 1'b0;
      end else begin
        res <= out_word;  // RULE1
        er_flag <= 1'b0;
        eq_flag <= (out_word == 16'h0000);  // RULE8
      end
    end
  end

  // sticky events; a new event wins over a write-one-to-clear in the same cycle
  wire [EVT_W-1:0] evt_set = {(state == ST_DONE) & done_err, state == ST_DONE};
  wire [EVT_W-1:0] evt_clr = (bus_wr && hit_stat) ? pwdata_i[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_evt = (evt & ~evt_clr) | evt_set;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) evt <= '0;
    else evt <= next_evt;
  end

  assign irq_o = |(evt & mask);

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_res_held_idle: assert property ((state != ST_DONE) |=> $stable(res))  // RULE1
    else $error("result changed without a completed evaluation");
  a_angle_over_err: assert property ((go && !go_addr && trig_bad) |=> (state == ST_DONE) ##1 er_flag)  // RULE5
    else $error("over-range angle did not raise the error flag");
  a_sine_sat: assert property ((cif.start && (go_op == OP_SINE) && (src == ANGLE_MAX_BCD))
    |-> ##[2:40] (res == SAT_BCD))  // RULE7
    else $error("sine of ninety did not saturate to 0.9999");
  a_trig_digits: assert property ((state == ST_DONE) && val_final && !err |-> bcd_ok(val))  // RULE6
    else $error("trig result holds a non-bcd digit");
  a_equal_result: assert property ((state == ST_DONE) && !done_err |=> (eq_flag == (res == 16'h0000)))  // RULE8
    else $error("equal flag disagrees with the result");
  a_err_keeps_dest: assert property ((state == ST_DONE) && done_err |=> $stable(res) && er_flag)  // RULE10
    else $error("failed evaluation touched the destination");
  a_ptr_bad_err: assert property ((state == ST_PTR) && ptr_bad |=> err && (state == ST_DONE))  // RULE9
    else $error("bad indirect pointer not flagged");
  a_node_exact: assert property ((state == ST_SEG) && seg_hit && seg_exact |=> (val == $past(yk_v)))  // RULE17
    else $error("breakpoint input did not yield its y value");
  a_div_length: assert property ($rose(state == ST_DIV) |-> (state == ST_DIV) [*8] ##[25:25] (state == ST_DONE))  // RULE15
    else $error("interpolation divide did not take 32 cycles");

endmodule : vcu_value_calc

// ---- tb_top.sv ----
// tb_top: self-checking bench for the value calculate unit, driven over apb.
// assumes the default data memory depth and a one-cycle apb access phase.
`timescale 1ns/1ps
module tb_top;
  import vcu_pkg::*;
  localparam logic [32:0] ALL_M = 33'h1FFFFFFFF;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [31:0] mask_v;
  logic [11:0] ra;
  logic [31:0] rdat;
  logic [15:0] tbl[7] = '{16'h0001, 16'h0020, 16'h0000, 16'h0010, 16'h0100, 16'h0020, 16'h0300};

  vcu_value_calc DUT (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic cmp(input logic [32:0] exp, input logic [32:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  // the watcher pairs every finished read with the oldest note; a zero mask is a poll
  always @(posedge ref_clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
      if (msk_q[0] != 33'h0) cmp(exp_q[0], {pslverr, prdata} & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // one apb transfer; request held until pready is seen high, bounded wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
    end
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    if (n >= 50) begin
      failures++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask : rdc

  // start one evaluation, poll the sticky done bit, check result, flags and irq
  task automatic eval(input logic [15:0] src, input logic [31:0] ctrl,
                      input logic [15:0] res, input logic [11:0] st);
    int n;
    n = 0;
    wr(OFF_SRC, {16'h0, src});
    wr(OFF_CTRL, ctrl | 32'h80000000);
    do begin
      rdc(OFF_STAT, 33'h0, 33'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      final_report();
    end
    rdc(OFF_RES, {17'h0, res}, ALL_M);
    rdc(OFF_STAT, {21'h0, st}, 33'h603);
    cmp({32'h0, (st[0] & mask_v[0]) | (st[1] & mask_v[1])}, {32'h0, irq});
    wr(OFF_STAT, 32'h3);
    rdc(OFF_STAT, 33'h0, 33'h3);
    cmp(33'h0, {32'h0, irq});
  endtask : eval

  initial begin
    void'($urandom(11320));
    mask_v = 32'h1;
    repeat (20) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rdc(OFF_STAT, 33'h0, ALL_M);
    rdc(OFF_MASK, 33'h0, ALL_M);
    rdc(OFF_RES, 33'h0, ALL_M);
    rdc(12'h014, 33'h100000000, ALL_M);
    wr(OFF_MASK, mask_v);
    // operands staged without the execute bit must leave everything idle
    wr(OFF_SRC, 32'h0901);
    wr(OFF_CTRL, 32'h0);
    repeat (4) rdc(OFF_STAT, 33'h0, 33'h3);
    eval(16'h0300, 32'(OP_SINE), 16'h5000, 12'h001);
    eval(16'h0300, 32'(OP_COSINE), 16'h8660, 12'h001);
    eval(16'h0000, 32'(OP_SINE), 16'h0000, 12'h401);
    eval(16'h0900, 32'(OP_SINE), 16'h9999, 12'h001);
    eval(16'h0901, 32'(OP_SINE), 16'h9999, 12'h203);
    // an immediate code other than sine or cosine is refused like a bad angle
    eval(16'h0300, 32'h0002, 16'h9999, 12'h203);
    eval(16'h0000, 32'(OP_COSINE), 16'h9999, 12'h001);
    // from here only the error event may raise the interrupt
    mask_v = 32'h2;
    wr(OFF_MASK, mask_v);
    foreach (tbl[i]) wr(12'(OFF_DM_BASE + 4 * (16 + i)), {16'h0, tbl[i]});
    // every input/output form pair lands on the same midpoint value
    for (int f = 0; f < 4; f++) begin
      wr(12'(OFF_DM_BASE + 64), {16'h0, 2'(f), 14'h0001});
      eval(f[1] ? 16'h0018 : 16'h0015, 32'h10010, 16'h0200, 12'h001);
    end
    wr(12'(OFF_DM_BASE + 64), 32'h0001);
    eval(16'h0010, 32'h10010, 16'h0100, 12'h001);
    // a non-bcd source into a bcd-input table fails and keeps the destination
    eval(16'h001A, 32'h10010, 16'h0100, 12'h203);
    eval(16'h0000, 32'h10010, 16'h0000, 12'h401);
    wr(12'(OFF_DM_BASE + 4 * 250), 32'h0001);
    eval(16'h0010, 32'h100FA, 16'h0000, 12'h203);
    wr(12'(OFF_DM_BASE + 128), 32'h00AB);
    eval(16'h0010, 32'h30020, 16'h0000, 12'h203);
    wr(12'(OFF_DM_BASE + 132), 32'h0016);
    eval(16'h0010, 32'h30021, 16'h0100, 12'h001);
    // the result register ignores writes
    wr(OFF_RES, 32'h1234);
    rdc(OFF_RES, 33'h0100, ALL_M);
    // random memory words read back with upper half zero
    repeat (8) begin
      ra = 12'(OFF_DM_BASE + 4 * ($urandom % 16 + 64));
      rdat = $urandom;
      wr(ra, rdat);
      rdc(ra, {17'h0, rdat[15:0]}, ALL_M);
    end
    final_report();
  end
endmodule : tb_top
